// ===== common/eic_pkg.sv
package eic_pkg;
    // Memory interface data path width
    localparam int EIC_DATA_W = 32;
    // Shared RAM: 128 KB as 32K words of 32 bits
    localparam int EIC_RAM_BYTES = 131072;
    localparam int EIC_RAM_AW = 15;
    // Function field position in a control write
    localparam int EIC_FUNC_MSB = 31;
    localparam int EIC_FUNC_LSB = 29;
    // Function codes of a control write
    localparam logic [2:0] EIC_FN_FLASH_WR = 3'h0;
    localparam logic [2:0] EIC_FN_NP_RESET = 3'h1;
    localparam logic [2:0] EIC_FN_ADDR20 = 3'h2;
    localparam logic [2:0] EIC_FN_ADDR21 = 3'h3;
    localparam logic [2:0] EIC_FN_PROGRAM = 3'h4;
    localparam logic [2:0] EIC_FN_CFG_CLOCK = 3'h5;
    localparam logic [2:0] EIC_FN_SEM_EN = 3'h6;
    // Values after reset of the latched controls
    localparam logic EIC_RST_NP_RESET_N = 1'b0;
    localparam logic EIC_RST_ADDR_BIT = 1'b0;
    localparam logic EIC_RST_PROGRAM_N = 1'b1;
    localparam logic EIC_RST_SEM_EN = 1'b0;
    // Doorbell word indices inside the shared RAM
    localparam logic [14:0] EIC_DB_TO_NP_IDX = 15'h7fff;
    localparam logic [14:0] EIC_DB_TO_DSP_IDX = 15'h7ffe;
    // Network processor boot window: address bits 31..17 equal to this
    localparam logic [14:0] EIC_NP_BOOT_HI = 15'h0000;
    // Width of a configuration clock pulse in cycles
    localparam int EIC_CFG_CLK_CYCLES = 1;

    // One bus request, for either processor
    typedef struct packed {
        logic cs_flash_io;  // Chip enable 1 (flash / control)
        logic cs_ram;       // Chip enable 2 (shared RAM) or bus select
        logic we;           // Write strobe
        logic [31:0] addr;  // Byte address
        logic [31:0] data;  // Write data
    } eic_bus_req_t;
endpackage : eic_pkg

// ===== rtl/eic_dpram.sv
`timescale 1ns/1ps
// True dual-port RAM; each port runs on its own, neither stalls the other
module eic_dpram #(
    parameter int AW = 15,
    parameter int DW = 32
) (
    input wire logic clk,
    input wire logic a_en,
    input wire logic a_we,
    input wire logic [AW-1:0] a_addr,
    input wire logic [DW-1:0] a_wdata,
    output logic [DW-1:0] a_rdata,
    input wire logic b_en,
    input wire logic b_we,
    input wire logic [AW-1:0] b_addr,
    input wire logic [DW-1:0] b_wdata,
    output logic [DW-1:0] b_rdata
);
    // Storage array
    logic [DW-1:0] mem [0:(1<<AW)-1];

    // Both ports in one process so the array has one driver;
    // on a same-word write collision port B lands last and wins
    always_ff @(posedge clk) begin
        if (a_en) begin
            if (a_we) begin
                mem[a_addr] <= a_wdata;
            end
            a_rdata <= mem[a_addr];
        end
        if (b_en) begin
            if (b_we) begin
                mem[b_addr] <= b_wdata;
            end
            b_rdata <= mem[b_addr];
        end
    end
endmodule : eic_dpram

// ===== rtl/eic_glue.sv
`timescale 1ns/1ps
// Operation
// - Control write: function D31..29, value D0
// - Code 001 drives network processor reset
// - Code 010 latches flash address bit 20
// - Code 011 latches flash address bit 21
// - Code 100 drives configuration program pin
// - Code 101 pulses configuration clock once
// - Code 110 sets or clears semaphore enable
// - Semaphore enable cleared after every reset
// - Semaphore enable steers chip enable 1
// - 128 KB RAM, two independent ports
// - Signal processor doorbell interrupts network processor
// - Network processor doorbell interrupts signal processor
// - Shared RAM is network processor boot memory
// - Memory interface data path 32 bits
// - Comports not ready until configuration done
module eic_glue
    import eic_pkg::*;
(
    input wire logic mclk,
    input wire logic srst,
    input eic_bus_req_t dsp_req,
    output logic [EIC_DATA_W-1:0] dsp_rdata,
    input eic_bus_req_t np_req,
    output logic [EIC_DATA_W-1:0] np_rdata,
    input wire logic fpga_config_done,
    output logic comport_ready,
    output logic netproc_reset_n,
    output logic flash_upper_addr_bit20,
    output logic flash_upper_addr_bit21,
    output logic fpga_config_program_n,
    output logic fpga_config_clock,
    output logic sem_enable,
    output logic flash_access,
    output logic flash_write,
    output logic sem_access,
    output logic netproc_doorbell_irq_n,
    output logic dsp_doorbell_irq
);
    // Function field of a write word
    function automatic logic [2:0] func_of(input logic [31:0] d);
        func_of = d[EIC_FUNC_MSB:EIC_FUNC_LSB];
    endfunction : func_of

    // Word index of a byte address inside the shared RAM
    function automatic logic [EIC_RAM_AW-1:0] word_of(input logic [31:0] a);
        word_of = a[EIC_RAM_AW+1:2];
    endfunction : word_of

    // Configuration-done pin synchroniser
    logic done_meta_reg;
    logic done_sync_reg;
    always_ff @(posedge mclk) begin
        if (srst) begin
            done_meta_reg <= 1'b0;
            done_sync_reg <= 1'b0;
        end else begin
            done_meta_reg <= fpga_config_done;
            done_sync_reg <= done_meta_reg;
        end
    end

    // Decoded control write on chip enable 1
    logic fio_wr;
    logic [2:0] fn;
    logic ctl_wr;
    assign fio_wr = dsp_req.cs_flash_io & dsp_req.we;
    assign fn = func_of(dsp_req.data);
    // Any non-zero function is a control write, never a flash write
    assign ctl_wr = fio_wr & (fn != EIC_FN_FLASH_WR);

    // Latched control state
    logic np_reset_n_reg, np_reset_n_next;
    logic addr20_reg, addr20_next;
    logic addr21_reg, addr21_next;
    logic program_n_reg, program_n_next;
    logic cfg_clk_reg, cfg_clk_next;
    logic sem_en_reg, sem_en_next;

    // Next values of the control latches; each but the clock pulse holds until its own write
    always_comb begin
        np_reset_n_next = np_reset_n_reg;
        addr20_next = addr20_reg;
        addr21_next = addr21_reg;
        program_n_next = program_n_reg;
        cfg_clk_next = 1'b0;
        sem_en_next = sem_en_reg;
        if (ctl_wr) begin
            unique case (fn)
                // Network processor reset level
                EIC_FN_NP_RESET: np_reset_n_next = dsp_req.data[0];
                // Upper flash address bits
                EIC_FN_ADDR20: addr20_next = dsp_req.data[0];
                EIC_FN_ADDR21: addr21_next = dsp_req.data[0];
                // Program pin level
                EIC_FN_PROGRAM: program_n_next = dsp_req.data[0];
                // One clock pulse, data bit ignored
                EIC_FN_CFG_CLOCK: cfg_clk_next = 1'b1;
                // Semaphore enable
                EIC_FN_SEM_EN: sem_en_next = dsp_req.data[0];
                // Code 111 is not assigned: ignored
                default: cfg_clk_next = 1'b0;
            endcase
        end
    end

    // Control latches; reset values are the safe ones
    always_ff @(posedge mclk) begin
        if (srst) begin
            np_reset_n_reg <= EIC_RST_NP_RESET_N;
            addr20_reg <= EIC_RST_ADDR_BIT;
            addr21_reg <= EIC_RST_ADDR_BIT;
            program_n_reg <= EIC_RST_PROGRAM_N;
            cfg_clk_reg <= 1'b0;
            sem_en_reg <= EIC_RST_SEM_EN;
        end else begin
            np_reset_n_reg <= np_reset_n_next;
            addr20_reg <= addr20_next;
            addr21_reg <= addr21_next;
            program_n_reg <= program_n_next;
            cfg_clk_reg <= cfg_clk_next;
            sem_en_reg <= sem_en_next;
        end
    end

    // Chip enable 1 routing state
    logic flash_acc_reg, flash_acc_next;
    logic flash_wr_reg, flash_wr_next;
    logic sem_acc_reg, sem_acc_next;

    // Route chip enable 1: flash while semaphore off, semaphore while on.
    // Control writes never reach either target.
    always_comb begin
        flash_acc_next = 1'b0;
        flash_wr_next = 1'b0;
        sem_acc_next = 1'b0;
        if (dsp_req.cs_flash_io && !ctl_wr) begin
            if (sem_en_reg) begin
                sem_acc_next = 1'b1;
            end else begin
                flash_acc_next = 1'b1;
                flash_wr_next = dsp_req.we;
            end
        end
    end

    // Routing strobes, one cycle per access cycle
    always_ff @(posedge mclk) begin
        if (srst) begin
            flash_acc_reg <= 1'b0;
            flash_wr_reg <= 1'b0;
            sem_acc_reg <= 1'b0;
        end else begin
            flash_acc_reg <= flash_acc_next;
            flash_wr_reg <= flash_wr_next;
            sem_acc_reg <= sem_acc_next;
        end
    end

    // Shared RAM port selects; boot window decoded for the network side
    logic np_boot_hit;
    logic dsp_ram_en;
    logic np_ram_en;
    logic [EIC_RAM_AW-1:0] dsp_word;
    logic [EIC_RAM_AW-1:0] np_word;
    assign np_boot_hit = np_req.addr[31:17] == EIC_NP_BOOT_HI;
    assign np_ram_en = np_req.cs_ram & np_boot_hit;
    assign dsp_ram_en = dsp_req.cs_ram;
    assign dsp_word = word_of(dsp_req.addr);
    assign np_word = word_of(np_req.addr);

    // 128 KB store, each side on its own port so no side waits
    eic_dpram #(
        .AW(EIC_RAM_AW),
        .DW(EIC_DATA_W)
    ) u_ram (
        .clk(mclk),
        .a_en(dsp_ram_en),
        .a_we(dsp_req.we),
        .a_addr(dsp_word),
        .a_wdata(dsp_req.data),
        .a_rdata(dsp_rdata),
        .b_en(np_ram_en),
        .b_we(np_req.we),
        .b_addr(np_word),
        .b_wdata(np_req.data),
        .b_rdata(np_rdata)
    );

    // Doorbell events and their acknowledges
    logic db_np_set, db_np_clr, db_dsp_set, db_dsp_clr;
    assign db_np_set = dsp_ram_en & dsp_req.we & (dsp_word == EIC_DB_TO_NP_IDX);
    assign db_np_clr = np_ram_en & ~np_req.we & (np_word == EIC_DB_TO_NP_IDX);
    assign db_dsp_set = np_ram_en & np_req.we & (np_word == EIC_DB_TO_DSP_IDX);
    assign db_dsp_clr = dsp_ram_en & ~dsp_req.we & (dsp_word == EIC_DB_TO_DSP_IDX);

    // Doorbell flags and comport readiness
    logic irq_np_reg, irq_np_next;
    logic irq_dsp_reg, irq_dsp_next;
    logic ready_reg, ready_next;

    // Sticky flags: a read of the own doorbell word clears, a set wins
    always_comb begin
        irq_np_next = db_np_set | (irq_np_reg & ~db_np_clr);
        irq_dsp_next = db_dsp_set | (irq_dsp_reg & ~db_dsp_clr);
        // Comports report not ready until configuration completes
        ready_next = done_sync_reg;
    end

    // Flag registers
    always_ff @(posedge mclk) begin
        if (srst) begin
            irq_np_reg <= 1'b0;
            irq_dsp_reg <= 1'b0;
            ready_reg <= 1'b0;
        end else begin
            irq_np_reg <= irq_np_next;
            irq_dsp_reg <= irq_dsp_next;
            ready_reg <= ready_next;
        end
    end

    // Outputs, all from flip-flops; the network doorbell output through an inverter
    assign netproc_reset_n = np_reset_n_reg;
    assign flash_upper_addr_bit20 = addr20_reg;
    assign flash_upper_addr_bit21 = addr21_reg;
    assign fpga_config_program_n = program_n_reg;
    assign fpga_config_clock = cfg_clk_reg;
    assign sem_enable = sem_en_reg;
    assign flash_access = flash_acc_reg;
    assign flash_write = flash_wr_reg;
    assign sem_access = sem_acc_reg;
    assign netproc_doorbell_irq_n = ~irq_np_reg;
    assign dsp_doorbell_irq = irq_dsp_reg;
    assign comport_ready = ready_reg;

    // Checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);

    a_reset_write: assert property (ctl_wr && fn == EIC_FN_NP_RESET
        |=> netproc_reset_n == $past(dsp_req.data[0]))
        else $error("reset level not taken from data bit 0");
    a_addr20_write: assert property (ctl_wr && fn == EIC_FN_ADDR20
        |=> flash_upper_addr_bit20 == $past(dsp_req.data[0]))
        else $error("address bit 20 not latched");
    a_addr21_write: assert property (ctl_wr && fn == EIC_FN_ADDR21
        |=> flash_upper_addr_bit21 == $past(dsp_req.data[0]))
        else $error("address bit 21 not latched");
    a_program_write: assert property (ctl_wr && fn == EIC_FN_PROGRAM
        |=> fpga_config_program_n == $past(dsp_req.data[0]))
        else $error("program pin not driven from data bit 0");
    a_cfg_clk_single: assert property (ctl_wr && fn == EIC_FN_CFG_CLOCK
        |=> fpga_config_clock
        ##1 (!fpga_config_clock || $past(ctl_wr && fn == EIC_FN_CFG_CLOCK)))
        else $error("configuration clock pulse not single");
    a_cfg_clk_cause: assert property ($rose(fpga_config_clock)
        |-> $past(ctl_wr && fn == EIC_FN_CFG_CLOCK))
        else $error("configuration clock pulse without command");
    a_sem_write: assert property (ctl_wr && fn == EIC_FN_SEM_EN
        |=> sem_enable == $past(dsp_req.data[0]))
        else $error("semaphore enable not updated");
    a_sem_reset: assert property (@(posedge mclk) disable iff (1'b0)
        $past(srst) |-> !sem_enable)
        else $error("semaphore enable set after reset");
    a_route_sem: assert property (dsp_req.cs_flash_io && !ctl_wr
        |=> (sem_access == $past(sem_enable)) && (flash_access != $past(sem_enable)))
        else $error("chip enable 1 routed to wrong target");
    a_flash_pass: assert property (fio_wr && fn == EIC_FN_FLASH_WR && !sem_enable
        |=> flash_write)
        else $error("function 000 write not passed to flash");
    a_ctl_nopass: assert property (ctl_wr |=> !flash_access && !sem_access)
        else $error("control write leaked to flash");
    // Unassigned code 111 must leave reset and semaphore latches alone and give no clock pulse
    a_code7_ignored: assert property (ctl_wr && fn == 3'h7
        |=> $stable(netproc_reset_n) && $stable(sem_enable) && !fpga_config_clock)
        else $error("function 111 changed a control");
    a_np_doorbell: assert property (db_np_set |=> !netproc_doorbell_irq_n)
        else $error("network doorbell lost");
    a_dsp_doorbell: assert property (db_dsp_set |=> dsp_doorbell_irq)
        else $error("signal processor doorbell lost");
    // Pending doorbells stay up until the receiver reads its word
    a_np_bell_hold: assert property (!netproc_doorbell_irq_n && !db_np_clr
        |=> !netproc_doorbell_irq_n)
        else $error("network doorbell dropped unread");
    a_dsp_bell_hold: assert property (dsp_doorbell_irq && !db_dsp_clr
        |=> dsp_doorbell_irq)
        else $error("signal processor doorbell dropped unread");
    a_ctl_stable: assert property (!ctl_wr |=> $stable(netproc_reset_n)
        && $stable(fpga_config_program_n) && $stable(sem_enable)
        && $stable(flash_upper_addr_bit20) && $stable(flash_upper_addr_bit21))
        else $error("latched control changed without write");
    a_ready_done: assert property (!done_sync_reg |=> !comport_ready)
        else $error("comports ready before configuration done");

    c_np_release: cover property ($rose(netproc_reset_n));
    c_sem_route: cover property (sem_enable && sem_access);
    c_cfg_clk: cover property (fpga_config_clock);
    c_doorbells: cover property (!netproc_doorbell_irq_n ##[1:20] dsp_doorbell_irq);
endmodule : eic_glue

// ===== testbench/eic_np_model.sv
`timescale 1ns/1ps
// Network processor side: boot fetch, doorbell service, doorbell ring
module eic_np_model
    import eic_pkg::*;
(
    input wire logic mclk,
    input wire logic srst,
    input wire logic reset_n,
    input wire logic irq_n,
    input wire logic ring,
    input wire logic [31:0] np_rdata,
    output eic_bus_req_t np_req,
    output logic [31:0] got
);
    logic booted; // First fetch done after reset release
    logic pend; // Read data due at next falling edge
    logic [1:0] cnt; // Doorbell service delay, slow on purpose
    initial begin
        np_req = '0;
        got = '0;
        booted = 1'b0;
        pend = 1'b0;
        cnt = 2'h0;
    end
    // Requests change only at the falling edge, one cycle each
    always @(negedge mclk) begin
        // Released data lines do not keep the last value
        np_req.cs_ram <= 1'b0;
        np_req.we <= 1'b0;
        np_req.data <= ~np_req.data;
        np_req.addr <= ~np_req.addr;
        pend <= 1'b0;
        if (pend) begin
            got <= np_rdata;
        end
        if (srst) begin
            booted <= 1'b0;
            cnt <= 2'h0;
        end else if (ring) begin
            // Doorbell towards the signal processor
            np_req <= '{1'b0, 1'b1, 1'b1, 32'h0001_fff8, 32'h0000_00a5};
        end else if (reset_n && !booted) begin
            // Boot fetch of word 0 from the boot window
            booted <= 1'b1;
            pend <= 1'b1;
            np_req <= '{1'b0, 1'b1, 1'b0, 32'h0000_0000, 32'h0000_0000};
        end else if (!irq_n && reset_n) begin
            // Service the doorbell by reading its word, after a delay
            if (cnt == 2'h2) begin
                cnt <= 2'h0;
                np_req <= '{1'b0, 1'b1, 1'b0, 32'h0001_fffc, 32'h0000_0000};
            end else begin
                cnt <= cnt + 2'h1;
            end
        end
    end
endmodule : eic_np_model

// ===== testbench/tb_top.sv
`timescale 1ns/1ps
// Self-checking bench for the memory interface glue
module tb_top;
    import eic_pkg::*;
    logic mclk, srst, fpga_config_done, ring;
    eic_bus_req_t dsp_req, np_req;
    logic [31:0] dsp_rdata, np_rdata, np_got;
    logic comport_ready, netproc_reset_n, flash_upper_addr_bit20, flash_upper_addr_bit21;
    logic fpga_config_program_n, fpga_config_clock, sem_enable, flash_access;
    logic flash_write, sem_access, netproc_doorbell_irq_n, dsp_doorbell_irq;
    int n_fail, samples_checked, cycles;

    eic_glue uut (.mclk(mclk), .srst(srst), .dsp_req(dsp_req), .dsp_rdata(dsp_rdata),
        .np_req(np_req), .np_rdata(np_rdata), .fpga_config_done(fpga_config_done),
        .comport_ready(comport_ready), .netproc_reset_n(netproc_reset_n),
        .flash_upper_addr_bit20(flash_upper_addr_bit20),
        .flash_upper_addr_bit21(flash_upper_addr_bit21),
        .fpga_config_program_n(fpga_config_program_n), .fpga_config_clock(fpga_config_clock),
        .sem_enable(sem_enable), .flash_access(flash_access), .flash_write(flash_write),
        .sem_access(sem_access), .netproc_doorbell_irq_n(netproc_doorbell_irq_n),
        .dsp_doorbell_irq(dsp_doorbell_irq));
    eic_np_model np (.mclk(mclk), .srst(srst), .reset_n(netproc_reset_n),
        .irq_n(netproc_doorbell_irq_n), .ring(ring), .np_rdata(np_rdata),
        .np_req(np_req), .got(np_got));

    // 40 MHz clock
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    // Hang guard, well above the fewer than 100 cycles the run needs
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            n_fail++;
            finish_test();
        end
    end
    // Verdict and end of run
    task finish_test();
        if (n_fail == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : finish_test
    // Compare one value, X never matches
    task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    // One signal processor cycle; returns when its answer is visible
    task dsp_cyc(input logic csf, input logic csr, input logic we, input logic [31:0] addr,
        input logic [31:0] data);
        @(negedge mclk);
        dsp_req <= '{csf, csr, we, addr, data};
        @(negedge mclk);
        dsp_req.cs_flash_io <= 1'b0;
        dsp_req.cs_ram <= 1'b0;
        dsp_req.we <= 1'b0;
        dsp_req.data <= ~data;
        dsp_req.addr <= ~addr;
    endtask : dsp_cyc
    // Control write: function in the top three bits, value in bit 0
    task ctl(input logic [2:0] fn, input logic v);
        dsp_cyc(1'b1, 1'b0, 1'b1, 32'h9000_0000, {fn, 28'h000_0000, v});
    endtask : ctl
    // Safe values after reset
    task t_reset();
        chk("np_reset_n", 32'h0, netproc_reset_n);
        chk("sem_en", 32'h0, sem_enable);
        chk("program_n", 32'h1, fpga_config_program_n);
        chk("bit20", 32'h0, flash_upper_addr_bit20);
        chk("bit21", 32'h0, flash_upper_addr_bit21);
        chk("comport_rdy", 32'h0, comport_ready);
    endtask : t_reset
    // Configure, load boot word, then release the network processor
    task t_boot();
        ctl(EIC_FN_PROGRAM, 1'b0);
        chk("program_n", 32'h0, fpga_config_program_n);
        ctl(EIC_FN_PROGRAM, 1'b1);
        chk("program_n", 32'h1, fpga_config_program_n);
        ctl(EIC_FN_CFG_CLOCK, 1'b0);
        chk("cfg_clock", 32'h1, fpga_config_clock);
        @(negedge mclk);
        chk("cfg_clock", 32'h0, fpga_config_clock);
        // Data bit 0 must not matter for the clock pulse
        ctl(EIC_FN_CFG_CLOCK, 1'b1);
        chk("cfg_clock", 32'h1, fpga_config_clock);
        @(negedge mclk);
        chk("cfg_clock", 32'h0, fpga_config_clock);
        chk("comport_rdy", 32'h0, comport_ready);
        fpga_config_done <= 1'b1;
        repeat (4) @(negedge mclk);
        chk("comport_rdy", 32'h1, comport_ready);
        dsp_cyc(1'b0, 1'b1, 1'b1, 32'ha000_0000, 32'h1234_5678);
        dsp_cyc(1'b0, 1'b1, 1'b0, 32'ha000_0000, 32'h0000_0000);
        chk("dsp_rdata", 32'h1234_5678, dsp_rdata);
        ctl(EIC_FN_NP_RESET, 1'b1);
        chk("np_reset_n", 32'h1, netproc_reset_n);
        repeat (3) @(negedge mclk);
        chk("np_boot", 32'h1234_5678, np_got);
    endtask : t_boot
    // Upper flash address bits, and the ignored code
    task t_addr();
        for (int i = 0; i < 2; i++) begin
            ctl(EIC_FN_ADDR20, !i[0]);
            ctl(EIC_FN_ADDR21, i[0]);
            chk("bit20", {31'h0, !i[0]}, flash_upper_addr_bit20);
            chk("bit21", {31'h0, i[0]}, flash_upper_addr_bit21);
        end
        ctl(3'h7, 1'b0);
        chk("flash_acc", 32'h0, flash_access);
        chk("bit21", 32'h1, flash_upper_addr_bit21);
        chk("np_reset_n", 32'h1, netproc_reset_n);
    endtask : t_addr
    // Chip enable 1 routing by the semaphore enable
    task t_route();
        ctl(EIC_FN_FLASH_WR, 1'b1);
        chk("flash_acc", 32'h1, flash_access);
        chk("flash_wr", 32'h1, flash_write);
        ctl(EIC_FN_SEM_EN, 1'b1);
        chk("sem_en", 32'h1, sem_enable);
        dsp_cyc(1'b1, 1'b0, 1'b0, 32'h0000_0100, 32'h0000_0000);
        chk("sem_acc", 32'h1, sem_access);
        chk("flash_acc", 32'h0, flash_access);
        ctl(EIC_FN_SEM_EN, 1'b0);
        chk("sem_en", 32'h0, sem_enable);
        dsp_cyc(1'b1, 1'b0, 1'b0, 32'h0000_0100, 32'h0000_0000);
        chk("flash_acc", 32'h1, flash_access);
        chk("flash_wr", 32'h0, flash_write);
    endtask : t_route
    // Doorbells in both directions
    task t_bell();
        dsp_cyc(1'b0, 1'b1, 1'b1, 32'h0001_fffc, 32'h0000_0001);
        chk("np_irq_n", 32'h0, netproc_doorbell_irq_n);
        for (int i = 0; i < 10 && netproc_doorbell_irq_n === 1'b0; i++) @(negedge mclk);
        chk("np_irq_n", 32'h1, netproc_doorbell_irq_n);
        @(negedge mclk);
        ring <= 1'b1;
        @(negedge mclk);
        ring <= 1'b0;
        @(negedge mclk);
        chk("dsp_irq", 32'h1, dsp_doorbell_irq);
        dsp_cyc(1'b0, 1'b1, 1'b0, 32'h0001_fff8, 32'h0000_0000);
        chk("dsp_rdata", 32'h0000_00a5, dsp_rdata);
        @(negedge mclk);
        chk("dsp_irq", 32'h0, dsp_doorbell_irq);
    endtask : t_bell
    // Mid-run reset must put every latch back to its safe value
    task t_rerun();
        ctl(EIC_FN_SEM_EN, 1'b1);
        ctl(EIC_FN_ADDR20, 1'b1);
        ctl(EIC_FN_PROGRAM, 1'b0);
        chk("sem_en", 32'h1, sem_enable);
        srst <= 1'b1;
        repeat (6) @(negedge mclk);
        srst <= 1'b0;
        @(negedge mclk);
        t_reset();
    endtask : t_rerun
    // Main sequence
    initial begin
        srst = 1'b1;
        dsp_req = '0;
        ring = 1'b0;
        fpga_config_done = 1'b0;
        n_fail = 0;
        samples_checked = 0;
        cycles = 0;
        repeat (6) @(negedge mclk);
        srst <= 1'b0;
        @(negedge mclk);
        t_reset();
        t_boot();
        t_addr();
        t_route();
        t_bell();
        t_rerun();
        finish_test();
    end
endmodule : tb_top
